// file: bench/sdic_ctrl_assertions.sv
`timescale 1ns/1ps
module sdic_ctrl_chk
    import sdic_pkg::*;
#(
    parameter int PWR_WAIT_CYC = PWR_CYC,
    parameter int CLK_SETTLE_CYC = CLK_STABLE_CYC
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic [ADDR_W-1:0] mode_word, // mode value
    input wire logic init_done, // idle after init
    input wire logic sr_active, // self-refresh in progress
    input wire logic sd_clk_en, // memory clock enable
    input wire logic sd_cke, // clock enable pin
    input wire logic sd_cs_n, // chip select
    input wire logic sd_ras_n, // row strobe
    input wire logic sd_cas_n, // column strobe
    input wire logic sd_we_n, // write enable
    input wire logic [ADDR_W-1:0] sd_addr, // address pins
    input wire logic [DQM_W-1:0] sd_dqm // data mask
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] cmd;
    logic issue;
    logic sr_cmd;
    logic [15:0] up_cnt, sr_cnt, en_cnt, x_cnt;
    logic [15:0] next_up_cnt, next_sr_cnt, next_en_cnt, next_x_cnt;
    logic [1:0] refs, next_refs;
    logic pre_seen, mrs_seen, next_pre_seen, next_mrs_seen;
    logic sr_seen, next_sr_seen;
    assign cmd = {sd_ras_n, sd_cas_n, sd_we_n};
    assign issue = !sd_cs_n;
    assign sr_cmd = issue && !sd_cke && !sd_ras_n && !sd_cas_n;

    // saturate so that long idle spans never wrap into a false short count
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction

    always_comb begin
        next_up_cnt = sys_rst ? 16'h0 : inc(up_cnt);
        next_sr_cnt = sr_cmd ? 16'h1 : inc(sr_cnt);
        next_en_cnt = sd_clk_en ? inc(en_cnt) : 16'h0;
        next_x_cnt = sd_cke ? inc(x_cnt) : 16'h0;
        next_refs = (issue && sd_cke && cmd == CMD_REF && refs != 2'h3) ? refs + 2'h1 : refs;
        next_pre_seen = pre_seen | (issue && cmd == CMD_PRE);
        next_mrs_seen = mrs_seen | (issue && cmd == CMD_MRS);
        // once self-refresh has been used, x_cnt times every later command from the last cke rise
        next_sr_seen = sr_seen | sr_cmd;
        if (sys_rst) begin
            next_refs = 2'h0;
            next_sr_seen = 1'b0;
            next_pre_seen = 1'b0;
            next_mrs_seen = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        up_cnt <= next_up_cnt;
        sr_cnt <= next_sr_cnt;
        en_cnt <= next_en_cnt;
        x_cnt <= next_x_cnt;
        refs <= next_refs;
        pre_seen <= next_pre_seen;
        mrs_seen <= next_mrs_seen;
        sr_seen <= next_sr_seen;
    end

    pwr_nop_a: assert property (!sd_cke && !sr_active |-> cmd == CMD_NOP && sd_dqm == '1)
        else $error("power-up pins not idle");
    pwr_wait_a: assert property ($rose(sd_cke) && !sr_active |-> up_cnt >= PWR_WAIT_CYC)
        else $error("clock enable raised too early");
    dqm_mask_a: assert property (!init_done |-> sd_dqm == '1)
        else $error("data mask dropped before idle");
    pre_all_a: assert property (issue && cmd == CMD_PRE |-> sd_addr[A10_POS])
        else $error("precharge without all-banks bit");
    mrs_word_a: assert property (issue && sd_cke && cmd == CMD_MRS |-> sd_addr == $past(mode_word))
        else $error("mode set with wrong word");
    init_seq_a: assert property ($rose(init_done) |-> refs >= 2'h2 && pre_seen && mrs_seen)
        else $error("idle before init steps done");
    sr_entry_a: assert property (sr_cmd |-> sd_we_n ##1 !sd_clk_en)
        else $error("bad self-refresh entry");
    sr_hold_a: assert property ($rose(sd_clk_en) |-> sr_cnt >= RAS_CYC)
        else $error("self-refresh left too soon");
    clk_settle_a: assert property ($rose(sd_cke) && sr_active |-> en_cnt >= CLK_SETTLE_CYC)
        else $error("clock not settled before exit");
    exit_desel_a: assert property ($rose(sd_cke) && sr_active |-> sd_cs_n)
        else $error("chip selected on exit");
    xsr_wait_a: assert property (issue && sd_cke && sr_seen && cmd != CMD_NOP |-> x_cnt >= XSR_CYC)
        else $error("command inside exit time");
    mrs_gap_a: assert property (issue && sd_cke && cmd == CMD_MRS |=> (sd_cs_n || cmd == CMD_NOP) [*3])
        else $error("command inside mode set time");

    cover property ($rose(init_done));
    cover property (sr_cmd);
    cover property ($rose(sd_cke) && sr_active);
endmodule

bind sdic_ctrl sdic_ctrl_chk #(.PWR_WAIT_CYC(PWR_WAIT_CYC), .CLK_SETTLE_CYC(CLK_SETTLE_CYC)) sdic_ctrl_chk_inst (
    .clk(clk), .sys_rst(sys_rst), .mode_word(mode_word), .init_done(init_done), .sr_active(sr_active),
    .sd_clk_en(sd_clk_en), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
    .sd_we_n(sd_we_n), .sd_addr(sd_addr), .sd_dqm(sd_dqm));

// file: bench/sdic_dev_model.sv
`timescale 1ns/1ps
module sdic_dev_model
    import sdic_pkg::*;
(
    input wire logic mclk, // gated memory clock
    input wire logic cke, // clock enable pin
    input wire logic cs_n, // chip select
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write enable
    input wire logic [ADDR_W-1:0] addr, // address pins
    output logic in_sr = 1'b0, // in self-refresh
    output logic [ADDR_W-1:0] mode_reg = '0, // loaded mode word
    output logic [15:0] n_ref = '0, // refreshes since power-up
    output logic [3:0] n_pre = '0, // precharge-all count
    output logic gap_err = 1'b0 // a command came too soon
);
    logic [2:0] cmd;
    int gap = 0;
    int need = 0;
    assign cmd = {ras_n, cas_n, we_n};

    always @(posedge mclk) begin
        gap <= gap + 1;
        if (in_sr) begin
            // only cke is looked at here, the clock may be stopped meanwhile
            if (cke) begin
                in_sr <= 1'b0;
                gap <= 1;
                need <= XSR_CYC;
            end
        end else if (!cke) begin
            if (!cs_n && cmd == CMD_REF) begin
                in_sr <= 1'b1;
            end else begin
                // cke low outside self-refresh reads as a fresh power-up
                n_ref <= '0;
                n_pre <= '0;
                need <= 0;
            end
        end else if (!cs_n && cmd != CMD_NOP) begin
            gap <= 1;
            if (gap < need) begin
                gap_err <= 1'b1;
            end
            case (cmd)
                CMD_PRE: begin
                    n_pre <= n_pre + {3'h0, addr[A10_POS]};
                    need <= RP_CYC;
                end
                CMD_MRS: begin
                    mode_reg <= addr;
                    need <= MRD_CYC;
                end
                CMD_REF: begin
                    n_ref <= n_ref + 16'h1;
                    need <= RFC_CYC;
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import sdic_pkg::*;
;
    localparam int PWR = 20;
    localparam logic [ADDR_W-1:0] MODE = 13'h0032;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] mode_word = MODE;
    logic burst_refresh_en = 1'b0;
    logic sr_req = 1'b0;
    logic init_done, sr_active, sd_clk_en, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
    logic [BA_W-1:0] sd_ba;
    logic [ADDR_W-1:0] sd_addr, mode_reg;
    logic [DQM_W-1:0] sd_dqm;
    logic en_lat = 1'b1;
    logic mclk, in_sr, gap_err;
    logic [15:0] n_ref;
    logic [3:0] n_pre;
    int n_mismatch = 0;
    int check_count = 0;

    always #2 clk = ~clk;
    // enable moves on the falling edge so the gated clock never glitches
    always @(negedge clk) en_lat <= sd_clk_en;
    assign mclk = clk & en_lat;

    sdic_ctrl #(.PWR_WAIT_CYC(PWR)) sdic_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .mode_word(mode_word),
        .burst_refresh_en(burst_refresh_en), .sr_req(sr_req), .init_done(init_done), .sr_active(sr_active),
        .sd_clk_en(sd_clk_en), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
        .sd_we_n(sd_we_n), .sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dqm(sd_dqm));
    sdic_dev_model sdic_dev_model_inst (.mclk(mclk), .cke(sd_cke), .cs_n(sd_cs_n), .ras_n(sd_ras_n),
        .cas_n(sd_cas_n), .we_n(sd_we_n), .addr(sd_addr), .in_sr(in_sr), .mode_reg(mode_reg),
        .n_ref(n_ref), .n_pre(n_pre), .gap_err(gap_err));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        sr_req <= 1'b0;
        burst_refresh_en <= 1'b0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic t_init();
        int n;
        n = 0;
        tick();
        while (sd_cke !== 1'b1 && n < 1000) begin
            check(32'(sd_dqm), 32'h3);
            tick();
            n++;
        end
        check(32'(n >= PWR), 32'h1);
        check(32'({sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}), 32'h17);
        n = 0;
        while (init_done !== 1'b1 && n < 1000) begin
            tick();
            n++;
        end
        check(32'(n_pre), 32'h1);
        check(32'(mode_reg), 32'(MODE));
        check(32'(n_ref), 32'h2);
        check(32'({init_done, gap_err, sd_dqm, sd_ba}), 32'h20);
    endtask

    // hold 0 drops the request at once, so exit must still wait out the row-active time
    task automatic t_sr(input int hold);
        int n;
        time t0;
        @(posedge clk);
        sr_req <= 1'b1;
        n = 0;
        while (sr_active !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        t0 = $time;
        check(32'({sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}), 32'h1);
        repeat (hold) begin
            tick();
            check(32'({sd_cke, sd_clk_en, in_sr}), 32'h1);
        end
        @(posedge clk);
        sr_req <= 1'b0;
        tick();
        // exit starts with the clock restart, so the row-active wait is timed to it
        while (sd_clk_en !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        check(32'(($time - t0) / 4 >= RAS_CYC), 32'h1);
        check(32'({sd_cke, sd_cs_n}), 32'h1);
        t0 = $time;
        while (sd_cke !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        check(32'(($time - t0) / 4 >= CLK_STABLE_CYC), 32'h1);
        check(32'({sd_cs_n, sd_clk_en}), 32'h3);
        t0 = $time;
        while (init_done !== 1'b1 && n < 600) begin
            tick();
            n++;
        end
        check(32'(($time - t0) / 4 >= XSR_CYC), 32'h1);
        check(32'({init_done, in_sr, gap_err, sr_active}), 32'h8);
    endtask

    // the full burst is too long to run, so a mid-burst reset cuts it short
    task automatic t_burst();
        logic [15:0] r0;
        r0 = n_ref;
        @(posedge clk);
        burst_refresh_en <= 1'b1;
        sr_req <= 1'b1;
        repeat (64) begin
            tick();
            check(32'({sd_cke, in_sr}), 32'h2);
        end
        check(32'(n_ref - r0 >= 16'h3), 32'h1);
        check(32'(gap_err), 32'h0);
        do_reset();
    endtask

    initial begin
        do_reset();
        t_init();
        t_sr(0);
        t_sr(40);
        t_burst();
        t_init();
        t_sr(2);
        complete_run();
    end

    initial begin
        #40000;
        n_mismatch++;
        complete_run();
    end
endmodule

// file: include/sdic_pkg.sv
package sdic_pkg;

    // clock and printed device timings
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_POWERUP_US = 200;
    localparam int T_RP_NS = 18;
    localparam int T_RFC_NS = 60;
    localparam int T_RC_NS = 60;
    localparam int T_MRD_NS = 12;
    localparam int T_RAS_NS = 42;
    localparam int T_IS_PS = 1500;
    localparam int PS_PER_NS = 1000;
    localparam int PS_PER_US = 1000000;

    // least times round up to whole cycles, never below one
    function automatic int min_cyc(input int t_ps);
        int c;
        c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PWR_CYC = min_cyc(T_POWERUP_US * PS_PER_US);
    localparam int RP_CYC = min_cyc(T_RP_NS * PS_PER_NS);
    localparam int RFC_CYC = min_cyc(T_RFC_NS * PS_PER_NS);
    localparam int MRD_CYC = min_cyc(T_MRD_NS * PS_PER_NS);
    localparam int RAS_CYC = min_cyc(T_RAS_NS * PS_PER_NS);
    localparam int XSR_CYC = min_cyc(T_RC_NS * PS_PER_NS + T_IS_PS);
    localparam int CLK_STABLE_CYC = 16;

    localparam int TIMER_W = 16;
    localparam int REF_CNT_W = 14;
    localparam logic [REF_CNT_W-1:0] INIT_REFS = 14'h0002;
    localparam logic [REF_CNT_W-1:0] BURST_REFS = 14'h2000;

    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int DQM_W = 2;
    localparam int A10_POS = 10;

    // {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MRS = 3'h0;

    typedef enum logic [3:0] {
        S_RST = 4'h0,
        S_PWR = 4'h1,
        S_CKE = 4'h3,
        S_PRE = 4'h2,
        S_PRE_W = 4'h6,
        S_MRS = 4'h7,
        S_MRS_W = 4'h5,
        S_REF = 4'h4,
        S_REF_W = 4'hc,
        S_IDLE = 4'hd,
        S_SRE = 4'hf,
        S_SR_HOLD = 4'he,
        S_SR_CLK = 4'ha,
        S_SR_XSR = 4'hb
    } sdic_state_t;

    typedef enum logic [1:0] {
        PH_INIT = 2'h0,
        PH_PRE_SR = 2'h1,
        PH_POST_SR = 2'h3
    } sdic_phase_t;

endpackage

// file: logic/sdic_ctrl.sv
// What this block does
// [RULE1] during power-up hold CKE low, DQM high and a NOP on other pins
// [RULE2] run the clock at least 200 us before raising CKE
// [RULE3] keep DQM high throughout initialisation
// [RULE4] precharge all banks once CKE is high
// [RULE5] issue a mode register set during initialisation
// [RULE6] issue at least two auto refreshes before normal operation
// [RULE7] refreshes may come before or after the mode register set
// [RULE8] self-refresh entry is CS, RAS, CAS low with CKE low
// [RULE9] device ignores all but CKE one cycle after entry
// [RULE10] device stays in self-refresh while CKE stays low
// [RULE11] wait the minimum row-active time before starting exit
// [RULE12] restart the clock and let it settle before raising CKE
// [RULE13] hold CS high while CKE rises on exit
// [RULE14] wait the self-refresh exit time after CKE high before any command
// [RULE15] with burst refresh, 8192 refreshes before entry and after exit
// [RULE16] exit time equals row cycle time plus input set-up time
// [RULE17] row cycle time is at least 60 ns
// [RULE18] minimum row-active time before exit is 42 ns
// [RULE19] wait at least 12 ns after a mode register set
// [RULE20] self-refresh entry carries WE high, unlike mode register set
// [RULE21] no read or write until the whole initialisation has finished
`timescale 1ns/1ps
module sdic_ctrl
    import sdic_pkg::*;
#(
    parameter int PWR_WAIT_CYC = PWR_CYC,
    parameter int CLK_SETTLE_CYC = CLK_STABLE_CYC,
    parameter bit REF_BEFORE_MRS = 1'b0
) (
    input wire logic clk, // system clock, 250 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [ADDR_W-1:0] mode_word, // value loaded into the mode register
    input wire logic burst_refresh_en, // wrap self-refresh in refresh bursts
    input wire logic sr_req, // level: high asks for self-refresh
    output logic init_done, // initialisation complete, idle
    output logic sr_active, // self-refresh entry, hold or exit in progress
    output logic sd_clk_en, // enables the memory clock
    output logic sd_cke, // clock enable pin
    output logic sd_cs_n, // chip select, active low
    output logic sd_ras_n, // row strobe, active low
    output logic sd_cas_n, // column strobe, active low
    output logic sd_we_n, // write enable, active low
    output logic [BA_W-1:0] sd_ba, // bank address
    output logic [ADDR_W-1:0] sd_addr, // address pins
    output logic [DQM_W-1:0] sd_dqm // data mask pins
);

    sdic_state_t state;
    sdic_state_t next_state;
    sdic_phase_t phase;
    sdic_phase_t next_phase;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic [REF_CNT_W-1:0] next_ref_cnt;
    logic [REF_CNT_W-1:0] ref_goal;
    logic mrs_done;
    logic next_mrs_done;
    logic refs_done;
    logic next_refs_done;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_done;

    function automatic logic [TIMER_W-1:0] wait_of(input int cyc);
        return TIMER_W'(cyc - 1);
    endfunction

    sdic_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // init needs two, a burst needs the full count
    assign ref_goal = (phase == PH_INIT) ? INIT_REFS : BURST_REFS; // [RULE6] [RULE15]

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_ref_cnt = ref_cnt;
        next_mrs_done = mrs_done;
        next_refs_done = refs_done;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state)
            S_RST: begin
                tmr_load = 1'b1;
                tmr_val = wait_of(PWR_WAIT_CYC); // [RULE2]
                next_state = S_PWR;
            end
            S_PWR: begin
                if (tmr_done) begin
                    next_state = S_CKE; // [RULE2]
                end
            end
            S_CKE: begin
                next_state = S_PRE;
            end
            S_PRE: begin
                tmr_load = 1'b1;
                tmr_val = wait_of(RP_CYC);
                next_state = S_PRE_W;
            end
            S_PRE_W: begin
                if (tmr_done) begin
                    if (REF_BEFORE_MRS) begin
                        next_state = S_REF; // [RULE7]
                    end else begin
                        next_state = S_MRS; // [RULE7]
                    end
                end
            end
            S_MRS: begin
                tmr_load = 1'b1;
                tmr_val = wait_of(MRD_CYC); // [RULE19]
                next_mrs_done = 1'b1;
                next_state = S_MRS_W;
            end
            S_MRS_W: begin
                if (tmr_done) begin
                    if (refs_done) begin
                        next_state = S_IDLE; // [RULE21]
                    end else begin
                        next_state = S_REF;
                    end
                end
            end
            S_REF: begin
                tmr_load = 1'b1;
                tmr_val = wait_of(RFC_CYC);
                next_ref_cnt = ref_cnt + 1'b1;
                next_state = S_REF_W;
            end
            S_REF_W: begin
                if (tmr_done) begin
                    if (ref_cnt < ref_goal) begin
                        next_state = S_REF; // [RULE6] [RULE15]
                    end else begin
                        next_ref_cnt = '0;
                        if (phase == PH_INIT) begin
                            next_refs_done = 1'b1;
                            if (mrs_done) begin
                                next_state = S_IDLE; // [RULE21]
                            end else begin
                                next_state = S_MRS;
                            end
                        end else if (phase == PH_PRE_SR) begin
                            next_state = S_SRE; // [RULE15]
                        end else begin
                            next_phase = PH_INIT;
                            next_state = S_IDLE;
                        end
                    end
                end
            end
            S_IDLE: begin
                if (sr_req) begin
                    if (burst_refresh_en) begin
                        next_phase = PH_PRE_SR; // [RULE15]
                        next_state = S_REF;
                    end else begin
                        next_state = S_SRE;
                    end
                end
            end
            S_SRE: begin
                tmr_load = 1'b1;
                tmr_val = wait_of(RAS_CYC); // [RULE11] [RULE18]
                next_state = S_SR_HOLD;
            end
            S_SR_HOLD: begin
                // exit only once the row-active time is spent
                if (tmr_done && !sr_req) begin // [RULE11]
                    tmr_load = 1'b1;
                    tmr_val = wait_of(CLK_SETTLE_CYC); // [RULE12]
                    next_state = S_SR_CLK;
                end
            end
            S_SR_CLK: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = wait_of(XSR_CYC); // [RULE14] [RULE16] [RULE17]
                    next_state = S_SR_XSR;
                end
            end
            S_SR_XSR: begin
                if (tmr_done) begin // [RULE14]
                    if (burst_refresh_en) begin
                        next_phase = PH_POST_SR; // [RULE15]
                        next_state = S_REF;
                    end else begin
                        next_phase = PH_INIT;
                        next_state = S_IDLE;
                    end
                end
            end
            default: begin
                next_state = S_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= S_RST;
            phase <= PH_INIT;
            ref_cnt <= '0;
            mrs_done <= 1'b0;
            refs_done <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            ref_cnt <= next_ref_cnt;
            mrs_done <= next_mrs_done;
            refs_done <= next_refs_done;
        end
    end

    // pins follow the state being entered so every pin is a flop
    logic next_init_done;
    logic next_sr_active;
    logic next_clk_en;
    logic next_cke;
    logic next_cs_n;
    logic [2:0] next_cmd;
    logic [BA_W-1:0] next_ba;
    logic [ADDR_W-1:0] next_addr;
    logic [DQM_W-1:0] next_dqm;

    always_comb begin
        next_init_done = 1'b0;
        next_sr_active = 1'b0;
        next_clk_en = 1'b1;
        next_cke = 1'b1;
        next_cs_n = 1'b0;
        next_cmd = CMD_NOP;
        next_ba = '0;
        next_addr = '0;
        next_dqm = '1; // [RULE3]
        case (next_state)
            S_RST, S_PWR: begin
                next_cke = 1'b0; // [RULE1]
            end
            S_PRE: begin
                next_cmd = CMD_PRE; // [RULE4]
                next_addr[A10_POS] = 1'b1; // [RULE4]
            end
            S_MRS: begin
                next_cmd = CMD_MRS; // [RULE5] [RULE20]
                next_addr = mode_word;
            end
            S_REF: begin
                next_cmd = CMD_REF; // [RULE6]
            end
            S_IDLE: begin
                next_init_done = 1'b1; // [RULE21]
                next_dqm = '0;
            end
            S_SRE: begin
                next_cke = 1'b0; // [RULE8]
                next_cmd = CMD_REF; // [RULE8] [RULE20]
                next_sr_active = 1'b1;
            end
            S_SR_HOLD: begin
                // device ignores the clock now, so stop it to save power
                next_cke = 1'b0; // [RULE10]
                next_clk_en = 1'b0; // [RULE9]
                next_sr_active = 1'b1;
            end
            S_SR_CLK: begin
                next_cke = 1'b0; // [RULE12]
                next_cs_n = 1'b1; // [RULE13]
                next_sr_active = 1'b1;
            end
            S_SR_XSR: begin
                next_cs_n = 1'b1; // [RULE13] [RULE14]
                next_sr_active = 1'b1;
            end
            default: begin
                next_cmd = CMD_NOP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_done <= 1'b0;
            sr_active <= 1'b0;
            sd_clk_en <= 1'b1;
            sd_cke <= 1'b0; // [RULE1]
            sd_cs_n <= 1'b0;
            sd_ras_n <= CMD_NOP[2];
            sd_cas_n <= CMD_NOP[1];
            sd_we_n <= CMD_NOP[0];
            sd_ba <= '0;
            sd_addr <= '0;
            sd_dqm <= '1; // [RULE1]
        end else begin
            init_done <= next_init_done;
            sr_active <= next_sr_active;
            sd_clk_en <= next_clk_en;
            sd_cke <= next_cke;
            sd_cs_n <= next_cs_n;
            sd_ras_n <= next_cmd[2];
            sd_cas_n <= next_cmd[1];
            sd_we_n <= next_cmd[0];
            sd_ba <= next_ba;
            sd_addr <= next_addr;
            sd_dqm <= next_dqm;
        end
    end

endmodule

// file: logic/sdic_timer.sv
`timescale 1ns/1ps
module sdic_timer
    import sdic_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic load, // restart the count
    input wire logic [W-1:0] load_val, // cycles to wait after load
    output logic done // count has reached zero
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == '0);

endmodule
